// [charger_pkg.sv]
// Purpose: shared constants of the input-limit and power-path control block
// Assumes: 20 MHz system clock, currents in 100 mA codes, register data 8 bits wide
// Notes:   register offsets are byte addresses on the plain register port
package charger_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned BUCK_DELAY_MS = 30;
   localparam int unsigned BUCK_DELAY_CYC = (BUCK_DELAY_MS * CLK_HZ + 999) / 1000;
   localparam int unsigned OPT_STEP_CYC = 16;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [3:0] REG_EXTERNAL_LIMIT_PIN = 4'h0;
   localparam logic [3:0] REG_VLIM = 4'h1;
   localparam logic [3:0] REG_CTRL = 4'h2;
   localparam logic [3:0] REG_BUCK = 4'h3;
   localparam logic [3:0] REG_SYSMIN = 4'h4;
   localparam logic [3:0] REG_OPTLIM = 4'h5;
   localparam logic [3:0] REG_STAT = 4'h6;
   localparam logic [3:0] REG_PATH = 4'h7;
   localparam logic [3:0] REG_EFFLIM = 4'h8;
   // ----------------------------------------
   // control, buck and status register bit positions
   // ----------------------------------------
   localparam int CTRL_OPT_EN = 0;
   localparam int CTRL_FORCE = 1;
   localparam int CTRL_PIN_EN = 2;
   localparam int CTRL_HIZ = 3;
   localparam int CTRL_CHG_EN = 4;
   localparam int CTRL_BUCK_EN = 5;
   localparam int CTRL_ADC_EN = 6;
   localparam int BUCK_CUR_LSB = 0;
   localparam int BUCK_VOLT_LSB = 4;
   localparam int STAT_FLAG = 2;
   localparam int STAT_SRC_LSB = 3;
   localparam int STAT_SYSREG = 6;
   // ----------------------------------------
   // reset values and codes
   // ----------------------------------------
   localparam logic [7:0] CTRL_RESET = 8'h15;
   localparam logic [5:0] EXTERNAL_LIMIT_PIN_RESET = 6'h05;
   localparam logic [7:0] VLIM_RESET = 8'h00;
   localparam logic [5:0] OPT_MIN_CODE = 6'h05;
   localparam logic [2:0] BUCK_CUR_RESET = 3'h0;
   localparam logic [2:0] BUCK_CUR_MAX = 3'h6;
   localparam logic [3:0] BUCK_VOLT_RESET = 4'h6;
   localparam logic [3:0] SYSMIN_RESET = 4'h6;
   localparam logic [2:0] SRC_DCP = 3'h3;
   localparam logic [2:0] SRC_BUCK = 3'h7;
   localparam logic [1:0] OPT_STAT_IDLE = 2'h0;
   localparam logic [1:0] OPT_STAT_RUN = 2'h1;
   localparam logic [1:0] OPT_STAT_FOUND = 2'h2;
   typedef enum {OPT_IDLE, OPT_RUN, OPT_DONE} opt_state_t;
endpackage

// [charger_input_limit_and_path_control.sv]
// Purpose: input current optimiser, effective input limit, buck (OTG) qualification and power path
// Assumes: comparator inputs are asynchronous pins; source detection and limit pin code share sys_clk
// Notes:   registers live on a plain port, read data one cycle after the read strobe
// Notes on behaviour
// - optimiser enabled after reset; software clears the enable bit to disable it.
// - optimiser starts by itself on dedicated charging port detection, an OVP rise or a high impedance change.
// - setting the force bit runs the optimiser whatever source was detected.
// - optimiser limit is the effective limit when enabled, else the input limit register.
// - effective limit is also clamped to the limit pin unless its enable bit is 0.
// - optimiser adjusts its limit until done; the flag sets on any status change.
// - battery below minimum system voltage: optimiser starts from the input limit register.
// - battery above minimum system voltage: optimiser starts from 500 mA.
// - listed events rerun the optimiser and put its status back to 01.
// - buck current code 000 is 500 mA; settings stop at 2.0 A.
// - buck starts only with all entry conditions and 30 ms after enabling.
// - buck mode reports source status 111; output voltage code defaults to 5.1 V.
// - buck stays on while battery and bus stay above thresholds; ADC may go off.
// - minimum system voltage field defaults to 6.2 V and holds up the system.
// - low battery runs the switch linear; idle charging tracks battery plus 50 mV.
// - system regulation status is high while held at minimum system voltage.
// - input over current or under voltage reduces charge current.
// - input voltage and current regulation status bits show the active limit.
// - zero charge current and system below battery turns the switch on (supplement).
// - battery below depletion threshold turns the switch off, ending supplement.
// - input current is limited to the lowest of register, enabled pin and enabled optimiser.
`timescale 1ns/100ps
`default_nettype none
module charger_input_limit_and_path_control #(
   parameter int unsigned BUCK_DELAY_CYCLES = charger_pkg::BUCK_DELAY_CYC,
   parameter int unsigned OPT_STEP_CYCLES = charger_pkg::OPT_STEP_CYC
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clkEn,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wstb,
   input wire logic rstb,
   output logic [7:0] rdata,
   input wire logic srcValid,
   input wire logic [2:0] srcType,
   input wire logic [5:0] srcLimit,
   input wire logic [5:0] externalLimitPin,
   input wire logic batAboveSysMin,
   input wire logic batAboveBuck,
   input wire logic batAboveDeplete,
   input wire logic busAbovePresent,
   input wire logic busOvp,
   input wire logic inOverCurrent,
   input wire logic inUnderVoltage,
   input wire logic sysBelowBat,
   input wire logic chgCurrentZero,
   input wire logic thermInWindow,
   input wire logic chargeTerminated,
   output logic [5:0] effLimit,
   output logic chargeReduce,
   output logic buckActive,
   output logic [2:0] buckCurrentCode,
   output logic [3:0] buckVoltageCode,
   output logic [3:0] sysMinCode,
   output logic batSwitchOn,
   output logic batSwitchLinear,
   output logic sysTrackBat
);
   import charger_pkg::*;

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   if (OPT_STEP_CYCLES < 1 || OPT_STEP_CYCLES > 65535) begin : g_bad_step
      $error("optimiser step interval out of range");
   end
   if (BUCK_DELAY_CYCLES < 1 || BUCK_DELAY_CYCLES > 1048575) begin : g_bad_delay
      $error("buck delay out of range");
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [10:0] pinMeta;
   logic [10:0] pinSync;
   logic sBatSysMin, sBatBuck, sBatDeplete, sBusPresent, sOvp, sOverCur, sUnderVolt;
   logic sSysBelowBat, sChgZero, sTherm, sTerm;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pinMeta <= '0;
         pinSync <= '0;
      end else if (clkEn) begin
         pinMeta <= {batAboveSysMin, batAboveBuck, batAboveDeplete, busAbovePresent, busOvp,
                     inOverCurrent, inUnderVoltage, sysBelowBat, chgCurrentZero, thermInWindow,
                     chargeTerminated};
         pinSync <= pinMeta;
      end
   end
   assign {sBatSysMin, sBatBuck, sBatDeplete, sBusPresent, sOvp, sOverCur, sUnderVolt,
           sSysBelowBat, sChgZero, sTherm, sTerm} = pinSync;

   // ----------------------------------------
   // register file
   // ----------------------------------------
   logic [5:0] ilimReg;
   logic [7:0] vlimReg;
   logic [7:0] ctrlReg;
   logic [5:0] optLimit;
   logic [1:0] optStat;
   logic [1:0] optStatPrev;
   logic changeFlag;
   logic [2:0] srcStat;
   logic sysRegStatus, iinRegStatus, vinRegStatus, supplement;
   logic wrIlim, wrVlim, wrCtrl, forceSet, hizPrev, ovpPrev, rerun, autoStart, otherSrc;
   logic [5:0] ilimNew;

   assign wrIlim = wstb && addr == REG_EXTERNAL_LIMIT_PIN;
   assign wrVlim = wstb && addr == REG_VLIM;
   assign wrCtrl = wstb && addr == REG_CTRL;
   assign forceSet = wrCtrl && wdata[CTRL_FORCE];
   assign autoStart = srcValid && srcType == SRC_DCP;
   assign otherSrc = srcValid && srcType != SRC_DCP;
   // start value follows a limit that is being loaded in the same cycle
   assign ilimNew = wrIlim ? wdata[5:0] : (srcValid ? srcLimit : ilimReg);
   // any of these reruns the optimiser from its start value
   assign rerun = ctrlReg[CTRL_OPT_EN] && (autoStart || forceSet || wrIlim || wrVlim
                  || (ctrlReg[CTRL_HIZ] != hizPrev) || (sOvp && !ovpPrev));

   // writable limit registers; detection loads the input limit too
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ilimReg <= EXTERNAL_LIMIT_PIN_RESET;
         vlimReg <= VLIM_RESET;
      end else if (clkEn) begin
         if (wrIlim) begin
            ilimReg <= wdata[5:0];
         end else if (srcValid) begin
            ilimReg <= srcLimit;
         end
         if (wrVlim) begin
            vlimReg <= wdata;
         end
      end
   end

   // control bits; force run clears itself once taken
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ctrlReg <= CTRL_RESET;
         buckCurrentCode <= BUCK_CUR_RESET;
         buckVoltageCode <= BUCK_VOLT_RESET;
         sysMinCode <= SYSMIN_RESET;
         hizPrev <= 1'b0;
         ovpPrev <= 1'b0;
      end else if (clkEn) begin
         hizPrev <= ctrlReg[CTRL_HIZ];
         ovpPrev <= sOvp;
         if (wrCtrl) begin
            ctrlReg <= wdata;
            ctrlReg[CTRL_FORCE] <= 1'b0;
         end else if (srcValid) begin
            ctrlReg[CTRL_HIZ] <= 1'b0; // plug-in releases high impedance
         end
         if (wstb && addr == REG_BUCK) begin
            // codes above 2.0 A are clamped, never stored
            buckCurrentCode <= (wdata[2:0] > BUCK_CUR_MAX) ? BUCK_CUR_MAX : wdata[2:0];
            buckVoltageCode <= wdata[BUCK_VOLT_LSB +: 4];
         end
         if (wstb && addr == REG_SYSMIN) begin
            sysMinCode <= wdata[3:0];
         end
      end
   end

   // read port, data valid in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata <= 8'h00;
      end else if (clkEn) begin
         rdata <= 8'h00;
         if (rstb) begin
            case (addr)
               REG_EXTERNAL_LIMIT_PIN: rdata <= {2'h0, ilimReg};
               REG_VLIM: rdata <= vlimReg;
               REG_CTRL: rdata <= ctrlReg;
               REG_BUCK: rdata <= {buckVoltageCode, 1'b0, buckCurrentCode};
               REG_SYSMIN: rdata <= {4'h0, sysMinCode};
               REG_OPTLIM: rdata <= {2'h0, optLimit};
               REG_STAT: rdata <= {1'b0, sysRegStatus, srcStat, changeFlag, optStat};
               REG_PATH: rdata <= {3'h0, buckActive, supplement, batSwitchOn, vinRegStatus,
                                   iinRegStatus};
               REG_EFFLIM: rdata <= {2'h0, effLimit};
               default: rdata <= 8'h00;
            endcase
         end
      end
   end

   // ----------------------------------------
   // input current optimiser
   // ----------------------------------------
   opt_state_t optState;
   logic [15:0] stepCnt;
   logic stepDone;
   assign stepDone = stepCnt == 16'(OPT_STEP_CYCLES - 1);

   // walks the limit up until the input sags or the register ceiling is met
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         optState <= OPT_IDLE;
         optStat <= OPT_STAT_IDLE;
         optLimit <= OPT_MIN_CODE;
         stepCnt <= 16'h0000;
      end else if (clkEn) begin
         if (!ctrlReg[CTRL_OPT_EN]) begin
            optState <= OPT_IDLE;
            optStat <= OPT_STAT_IDLE;
         end else if (rerun) begin
            optState <= OPT_RUN;
            optStat <= OPT_STAT_RUN;
            optLimit <= sBatSysMin ? OPT_MIN_CODE : ilimNew;
            stepCnt <= 16'h0000;
         end else if (otherSrc) begin
            optState <= OPT_IDLE; // other adapters stop it; one that releases high impedance reruns it a cycle later
            optStat <= OPT_STAT_IDLE;
         end else begin
            case (optState)
               OPT_RUN: begin
                  stepCnt <= stepDone ? 16'h0000 : stepCnt + 16'h0001;
                  if (stepDone) begin
                     if (sUnderVolt) begin
                        // back off one step so the adapter leaves voltage regulation
                        if (optLimit > OPT_MIN_CODE) begin
                           optLimit <= optLimit - 6'h01;
                        end
                        optState <= OPT_DONE;
                        optStat <= OPT_STAT_FOUND;
                     end else if (optLimit >= ilimReg) begin
                        optState <= OPT_DONE;
                        optStat <= OPT_STAT_FOUND;
                     end else begin
                        optLimit <= optLimit + 6'h01;
                     end
                  end
               end
               OPT_DONE: optState <= OPT_DONE; // limit frozen until a rerun
               OPT_IDLE: optState <= OPT_IDLE;
               default: optState <= OPT_IDLE;
            endcase
         end
      end
   end

   // change flag: a new change beats a clearing read in the same cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         optStatPrev <= OPT_STAT_IDLE;
         changeFlag <= 1'b0;
      end else if (clkEn) begin
         optStatPrev <= optStat;
         if (optStat != optStatPrev) begin
            changeFlag <= 1'b1;
         end else if (rstb && addr == REG_STAT) begin
            changeFlag <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // effective input current limit
   // ----------------------------------------
   logic [5:0] next_effLimit;

   // lowest of register, enabled pin and enabled optimiser
   always_comb begin
      next_effLimit = ctrlReg[CTRL_OPT_EN] ? optLimit : ilimReg;
      if (ilimReg < next_effLimit) begin
         next_effLimit = ilimReg;
      end
      if (ctrlReg[CTRL_PIN_EN] && externalLimitPin < next_effLimit) begin
         next_effLimit = externalLimitPin;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         effLimit <= EXTERNAL_LIMIT_PIN_RESET;
      end else if (clkEn) begin
         effLimit <= next_effLimit;
      end
   end

   // ----------------------------------------
   // buck (OTG) mode
   // ----------------------------------------
   logic [19:0] buckTimer;
   logic buckReq, buckTimerDone, busSeen;
   assign buckReq = ctrlReg[CTRL_BUCK_EN] && !ctrlReg[CTRL_CHG_EN];
   assign buckTimerDone = buckTimer == 20'(BUCK_DELAY_CYCLES);

   // entry delay restarts whenever the request drops
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         buckTimer <= 20'h00000;
      end else if (clkEn) begin
         if (!buckReq) begin
            buckTimer <= 20'h00000;
         end else if (!buckTimerDone) begin
            buckTimer <= buckTimer + 20'h00001;
         end
      end
   end

   // bus check only bites once our own output has come up
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         buckActive <= 1'b0;
         busSeen <= 1'b0;
      end else if (clkEn) begin
         if (!buckActive) begin
            busSeen <= 1'b0;
            buckActive <= buckReq && buckTimerDone && sBatBuck && !sBusPresent
                          && ctrlReg[CTRL_ADC_EN] && sTherm;
         end else begin
            busSeen <= busSeen || sBusPresent;
            if (!buckReq || !sBatBuck || (busSeen && !sBusPresent)) begin
               buckActive <= 1'b0;
            end
         end
      end
   end

   // source status follows detection, overridden in buck mode
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         srcStat <= 3'h0;
      end else if (clkEn) begin
         if (buckActive) begin
            srcStat <= SRC_BUCK;
         end else if (srcValid) begin
            srcStat <= srcType;
         end else if (srcStat == SRC_BUCK) begin
            srcStat <= 3'h0;
         end
      end
   end

   // ----------------------------------------
   // power path and dynamic power management
   // ----------------------------------------
   // status and switch mode follow the synchronised comparators
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sysRegStatus <= 1'b0;
         batSwitchLinear <= 1'b0;
         sysTrackBat <= 1'b0;
         iinRegStatus <= 1'b0;
         vinRegStatus <= 1'b0;
         chargeReduce <= 1'b0;
      end else if (clkEn) begin
         sysRegStatus <= !sBatSysMin && !buckActive;
         batSwitchLinear <= !sBatSysMin && !supplement;
         sysTrackBat <= sBatSysMin && (!ctrlReg[CTRL_CHG_EN] || sTerm);
         iinRegStatus <= sOverCur && !buckActive;
         vinRegStatus <= sUnderVolt && !buckActive;
         chargeReduce <= (sOverCur || sUnderVolt) && !buckActive;
      end
   end

   // supplement: battery helps once charge current is gone and system sags
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         supplement <= 1'b0;
         batSwitchOn <= 1'b0;
      end else if (clkEn) begin
         if (!sBatDeplete) begin
            supplement <= 1'b0;
            batSwitchOn <= 1'b0;
         end else begin
            if (sChgZero && sSysBelowBat) begin
               supplement <= 1'b1;
            end else if (!sSysBelowBat) begin
               supplement <= 1'b0;
            end
            batSwitchOn <= (sChgZero && sSysBelowBat) || buckActive
                           || (sBatSysMin && ctrlReg[CTRL_CHG_EN] && !sTerm);
         end
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   opt_default_a: assert property ($fell(srst) |-> ctrlReg[CTRL_OPT_EN]) else $error("optimiser off after reset");
   dcp_start_a: assert property (clkEn && autoStart && ctrlReg[CTRL_OPT_EN] |=> optStat == OPT_STAT_RUN)
      else $error("dcp did not start optimiser");
   force_run_a: assert property (clkEn && forceSet && ctrlReg[CTRL_OPT_EN] |=> optState == OPT_RUN)
      else $error("force did not run optimiser");
   pin_clamp_a: assert property (clkEn && ctrlReg[CTRL_PIN_EN] |=> effLimit <= $past(externalLimitPin))
      else $error("limit pin not clamping");
   lowest_limit_a: assert property (clkEn |=> effLimit <= $past(ilimReg)) else $error("limit above register");
   flag_change_a: assert property (clkEn && optStat != optStatPrev |=> changeFlag)
      else $error("change flag missed");
   init_low_a: assert property (clkEn && rerun && !sBatSysMin |=> optLimit == ilimReg)
      else $error("bad start from register");
   init_min_a: assert property (clkEn && rerun && sBatSysMin |=> optLimit == OPT_MIN_CODE)
      else $error("bad start from minimum");
   buck_cur_a: assert property (buckCurrentCode <= BUCK_CUR_MAX) else $error("buck current above max");
   buck_delay_a: assert property ($rose(buckActive) |-> $past(buckTimerDone) && $past(buckReq))
      else $error("buck started early");
   buck_status_a: assert property (clkEn && buckActive |=> srcStat == SRC_BUCK)
      else $error("buck status wrong");
   buck_drop_a: assert property (clkEn && buckActive && !sBatBuck |=> !buckActive)
      else $error("buck kept on low battery");
   dpm_status_a: assert property (clkEn && sOverCur && !buckActive |=> iinRegStatus && chargeReduce)
      else $error("dpm status missing");
   supp_exit_a: assert property (clkEn && !sBatDeplete |=> !batSwitchOn && !supplement)
      else $error("switch on below depletion");

   opt_found_c: cover property (optStat == OPT_STAT_RUN ##[1:200] optStat == OPT_STAT_FOUND);
   buck_on_c: cover property ($rose(buckActive));
   supp_on_c: cover property ($rose(supplement));
endmodule
`default_nettype wire

// [usb_side.sv]
// Purpose: far side model: adapter plug-in and bus comparator levels
// Assumes: detection result arrives on sys_clk
// Notes:   levels hold until the bench calls bus again
`timescale 1ns/100ps
`default_nettype none
module usb_side (
   input wire logic sys_clk,
   output logic srcValid,
   output logic [2:0] srcType,
   output logic [5:0] srcLimit,
   output logic busAbovePresent,
   output logic busOvp,
   output logic inOverCurrent,
   output logic inUnderVoltage
);
   // ----------------------------------------
   // adapter actions
   // ----------------------------------------
   initial begin
      {srcValid, srcType, srcLimit, busAbovePresent, busOvp, inOverCurrent, inUnderVoltage} = '0;
   end
   // one-cycle detection pulse; code is garbage outside it
   task automatic plug(input logic [2:0] t, input logic [5:0] l);
      @(posedge sys_clk);
      srcValid <= 1'b1;
      srcType <= t;
      srcLimit <= l;
      @(posedge sys_clk);
      srcValid <= 1'b0;
      srcType <= ~t;
      srcLimit <= ~l;
   endtask
   // comparator levels seen at the input
   task automatic bus(input logic p, o, c, u);
      @(posedge sys_clk);
      {busAbovePresent, busOvp, inOverCurrent, inUnderVoltage} <= {p, o, c, u};
   endtask
endmodule
`default_nettype wire

// [charger_input_limit_and_path_control_test.sv]
// Purpose: self-checking bench of the input limit and path control
// Assumes: short buck delay and optimiser step for a fast run
// Notes:   register reads poll under a bounded count
`timescale 1ns/100ps
`default_nettype none
module charger_input_limit_and_path_control_test;
   import charger_pkg::*;
   logic sys_clk, srst, wstb, rstb, srcValid, busAbovePresent, busOvp, inOverCurrent, inUnderVoltage;
   logic batAboveSysMin, batAboveBuck, batAboveDeplete, sysBelowBat, chgCurrentZero, thermInWindow;
   logic chargeReduce, buckActive, batSwitchOn, batSwitchLinear, sysTrackBat;
   logic clkEn = 1'b1;
   logic chargeTerminated = 1'b0;
   logic [3:0] addr, buckVoltageCode, sysMinCode;
   logic [7:0] wdata, rdata;
   logic [2:0] srcType, buckCurrentCode;
   logic [5:0] srcLimit, externalLimitPin, effLimit;
   int fail_count = 0;
   int checked = 0;
   // ----------------------------------------
   // design, far side and bus tasks
   // ----------------------------------------
   charger_input_limit_and_path_control #(.BUCK_DELAY_CYCLES(20), .OPT_STEP_CYCLES(4)) dut (.sys_clk, .srst,
      .clkEn, .addr, .wdata, .wstb, .rstb, .rdata, .srcValid, .srcType, .srcLimit, .externalLimitPin,
      .batAboveSysMin, .batAboveBuck, .batAboveDeplete, .busAbovePresent, .busOvp, .inOverCurrent,
      .inUnderVoltage, .sysBelowBat, .chgCurrentZero, .thermInWindow, .chargeTerminated, .effLimit,
      .chargeReduce, .buckActive, .buckCurrentCode, .buckVoltageCode, .sysMinCode, .batSwitchOn,
      .batSwitchLinear, .sysTrackBat);
   usb_side usb (.sys_clk, .srcValid, .srcType, .srcLimit, .busAbovePresent, .busOvp, .inOverCurrent,
      .inUnderVoltage);
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic give_verdict;
      if (fail_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wstb <= 1'b1;
      @(posedge sys_clk);
      wstb <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      rstb <= 1'b1;
      @(posedge sys_clk);
      rstb <= 1'b0;
      #1 d = rdata;
   endtask
   // bounded poll; a lapse counts and ends the run
   task automatic poll(input string n, input logic [3:0] a, input logic [7:0] m, e);
      logic [7:0] d;
      int i;
      for (i = 0; i < 60; i++) begin
         rd(a, d);
         if ((d & m) === e) break;
      end
      chk(n, d & m, e);
      if (i == 60) give_verdict;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic s_reset;
      chk("volt code", buckVoltageCode, 8'h06);
      chk("sysmin code", sysMinCode, 8'h06);
      poll("ctrl", REG_CTRL, 8'hFF, CTRL_RESET);
      poll("buck cur", REG_BUCK, 8'h07, 8'h00);
   endtask
   task automatic s_dcp;
      usb.plug(SRC_DCP, 6'h0A);
      repeat (2) @(posedge sys_clk);
      #1 chk("opt start", effLimit, 8'h05);
      poll("opt found", REG_STAT, 8'h07, 8'h06);
      poll("flag clear", REG_STAT, 8'h07, 8'h02);
      poll("opt lim", REG_OPTLIM, 8'h3F, 8'h0A);
   endtask
   task automatic s_rerun;
      batAboveSysMin <= 1'b0;
      repeat (4) @(posedge sys_clk);
      wr(REG_EXTERNAL_LIMIT_PIN, 8'h0C);
      poll("rerun", REG_STAT, 8'h03, 8'h01);
      @(posedge sys_clk);
      #1 chk("start external_limit_pin", effLimit, 8'h0C);
      usb.bus(1'b0, 1'b1, 1'b0, 1'b0);
      poll("ovp rerun", REG_STAT, 8'h03, 8'h01);
      usb.bus(1'b0, 1'b0, 1'b0, 1'b0);
   endtask
   task automatic s_force;
      logic [2:0] t[4] = '{3'h1, 3'h2, 3'h5, 3'h6};
      foreach (t[i]) begin
         usb.plug(t[i], 6'h0C);
         poll("no auto run", REG_STAT, 8'h03, 8'h00);
      end
      wr(REG_CTRL, CTRL_RESET | 8'h02);
      poll("forced", REG_STAT, 8'h03, 8'h01);
      poll("force gone", REG_CTRL, 8'hFF, CTRL_RESET);
   endtask
   task automatic s_limits;
      wr(REG_CTRL, 8'h14);
      wr(REG_EXTERNAL_LIMIT_PIN, 8'h14);
      poll("external_limit_pin used", REG_EFFLIM, 8'h3F, 8'h14);
      externalLimitPin <= 6'h07;
      poll("pin clamp", REG_EFFLIM, 8'h3F, 8'h07);
      wr(REG_CTRL, 8'h10);
      poll("pin off", REG_EFFLIM, 8'h3F, 8'h14);
      chk("eff port", effLimit, 8'h14);
      clkEn <= 1'b0;
      wr(REG_EXTERNAL_LIMIT_PIN, 8'h20);
      clkEn <= 1'b1;
      poll("frozen", REG_EXTERNAL_LIMIT_PIN, 8'h3F, 8'h14);
      externalLimitPin <= 6'h3F;
   endtask
   task automatic s_buck;
      wr(REG_BUCK, 8'h67);
      poll("cur clamp", REG_BUCK, 8'h07, 8'h06);
      batAboveBuck <= 1'b1;
      thermInWindow <= 1'b1;
      wr(REG_CTRL, 8'h65);
      repeat (10) @(posedge sys_clk);
      #1 chk("buck early", buckActive, 8'h00);
      poll("buck on", REG_PATH, 8'h10, 8'h10);
      poll("src code", REG_STAT, 8'h38, 8'h38);
      wr(REG_CTRL, 8'h25);
      repeat (6) @(posedge sys_clk);
      #1 chk("adc off", buckActive, 8'h01);
      batAboveBuck <= 1'b0;
      poll("buck off", REG_PATH, 8'h10, 8'h00);
      chk("cur port", buckCurrentCode, 8'h06);
   endtask
   task automatic s_path;
      wr(REG_CTRL, CTRL_RESET);
      poll("sys reg", REG_STAT, 8'h40, 8'h40);
      chk("linear", batSwitchLinear, 8'h01);
      usb.bus(1'b0, 1'b0, 1'b1, 1'b0);
      poll("cur dpm", REG_PATH, 8'h03, 8'h01);
      chk("reduce", chargeReduce, 8'h01);
      usb.bus(1'b0, 1'b0, 1'b0, 1'b1);
      poll("volt dpm", REG_PATH, 8'h03, 8'h02);
      usb.bus(1'b0, 1'b0, 1'b0, 1'b0);
      poll("no dpm", REG_PATH, 8'h03, 8'h00);
      {chgCurrentZero, sysBelowBat, batAboveDeplete} <= 3'h7;
      poll("supplement", REG_PATH, 8'h0C, 8'h0C);
      batAboveDeplete <= 1'b0;
      poll("supp off", REG_PATH, 8'h0C, 8'h00);
      chk("switch off", batSwitchOn, 8'h00);
      batAboveSysMin <= 1'b1;
      wr(REG_CTRL, 8'h05);
      repeat (6) @(posedge sys_clk);
      #1 chk("track bat", sysTrackBat, 8'h01);
      chargeTerminated <= 1'b1;
      wr(REG_CTRL, CTRL_RESET);
      repeat (6) @(posedge sys_clk);
      #1 chk("track term", sysTrackBat, 8'h01);
   endtask
   // reset, then the scenarios in turn
   initial begin
      {addr, wdata, wstb, rstb, batAboveBuck, batAboveDeplete, sysBelowBat, chgCurrentZero, thermInWindow} = '0;
      externalLimitPin = 6'h3F;
      batAboveSysMin = 1'b1;
      srst = 1'b1;
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      s_reset();
      s_dcp();
      s_rerun();
      s_force();
      s_limits();
      s_buck();
      s_path();
      give_verdict();
   end
endmodule
`default_nettype wire
